// ===== core/swr_buf2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module swr_buf2 #(
  parameter int W = 44
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem [2];
  logic         wr_ptr;
  logic         rd_ptr;
  logic [1:0]   count;
  wire          push = in_valid && (count != 2'd2);
  wire          pop  = out_valid && out_ready;

  assign in_ready  = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'd0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : swr_buf2

// ===== core/swr_map.svh
// Constants for the start waveform recorder and remote order latches
// Functional notes
// - Store max current and VAC every five cycles
// - Stored samples are true RMS magnitudes
// - Only latest start recording kept, replaced
// - Capture begins on motor start detection
// - Capture ends when start time delay expires
// - Recording ends after at most 200 seconds
// - Pulse order mapped onto chosen output relays
// - Pulse order held active for 200 ms
// - Hold order mapped onto chosen output relays
// - Hold order latched until supervisor drops it
// - Hold-order relays follow the latched state
`ifndef SWR_MAP_SVH
`define SWR_MAP_SVH
`define SWR_CLK_HZ       20000000
`define SWR_PULSE_MS     200
`define SWR_REC_MAX_S    200
`define SWR_CYCLES_PER_SAMPLE 5
`define SWR_MAG_W        16
`define SWR_IDX_W        12
`define SWR_RELAYS       8
`define SWR_RESET_RELAYS 8'h00
`endif

// ===== core/swr_pkg.sv
// Types for the start waveform recorder
package swr_pkg;
  typedef logic [15:0] swr_mag_t;
  typedef logic [11:0] swr_idx_t;
  typedef logic [7:0]  swr_relay_t;
  typedef enum logic {SWR_IDLE, SWR_REC} swr_state_t;
endpackage : swr_pkg

// ===== core/swr_recorder.sv
// Start profile recorder and remote pulse/hold order outputs
`timescale 1ns/1ps
`include "swr_map.svh"
module swr_recorder #(
  parameter logic [31:0] PULSE_CYCLES   = 32'(`SWR_PULSE_MS * (`SWR_CLK_HZ / 1000)),
  parameter logic [31:0] REC_MAX_CYCLES = 32'(64'(`SWR_REC_MAX_S) * 64'(`SWR_CLK_HZ))
) (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                cycle_tick,
  input  wire swr_pkg::swr_mag_t   rms_current_a,
  input  wire swr_pkg::swr_mag_t   rms_current_b,
  input  wire swr_pkg::swr_mag_t   rms_current_c,
  input  wire swr_pkg::swr_mag_t   rms_vac,
  input  wire logic                start_detect,
  input  wire logic                start_time_delay,
  input  wire logic                remote_pulse_cmd,
  input  wire logic                remote_hold_set,
  input  wire logic                remote_hold_clear,
  input  wire swr_pkg::swr_relay_t pulse_relay_assignment,
  input  wire swr_pkg::swr_relay_t hold_relay_assignment,
  output swr_pkg::swr_relay_t      relay_out,
  output logic                     recording,
  output logic                     record_start,
  output logic                     sample_valid,
  input  wire logic                sample_ready,
  output swr_pkg::swr_mag_t        sample_current,
  output swr_pkg::swr_mag_t        sample_voltage,
  output swr_pkg::swr_idx_t        sample_index
);
  import swr_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  swr_state_t  state;
  logic [2:0]  cyc_cnt;
  logic [31:0] rec_cnt;
  logic [31:0] pulse_cnt;
  logic        hold_order;
  logic        pend;
  swr_mag_t    pend_cur;
  swr_mag_t    pend_volt;
  swr_idx_t    pend_idx;
  swr_idx_t    rec_index;
  logic        buf_ready;
  logic [31:0] pulse_len;

  // Largest line current
  wire swr_mag_t max_ab   = (rms_current_a > rms_current_b) ? rms_current_a : rms_current_b;
  wire swr_mag_t max_cur  = (max_ab > rms_current_c) ? max_ab : rms_current_c;
  wire           rec_cap  = (rec_cnt == REC_MAX_CYCLES - 32'd1);
  wire           rec_stop = start_time_delay || rec_cap;
  wire           take     = recording && cycle_tick && (cyc_cnt == 3'd0) && !start_detect;
  wire           pushed   = pend && buf_ready;
  wire           pulse_active = (pulse_cnt != 32'd0);
  wire swr_relay_t next_relay = (pulse_active ? pulse_relay_assignment : `SWR_RESET_RELAYS)
                              | (hold_order ? hold_relay_assignment : `SWR_RESET_RELAYS);

  assign recording = (state == SWR_REC);

  // Recording state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state        <= SWR_IDLE;
      record_start <= 1'b0;
      rec_cnt      <= 32'd0;
      cyc_cnt      <= 3'd0;
    end else begin
      record_start <= start_detect;
      case (state)
        SWR_IDLE: begin
          if (start_detect) begin
            state <= SWR_REC;
          end
        end
        SWR_REC: begin
          if (start_detect) begin
            state <= SWR_REC;
          end else if (rec_stop) begin
            state <= SWR_IDLE;
          end
        end
        default: state <= SWR_IDLE;
      endcase
      if (start_detect) begin
        rec_cnt <= 32'd0;
        cyc_cnt <= 3'd0;
      end else if (recording) begin
        rec_cnt <= rec_cap ? rec_cnt : rec_cnt + 32'd1;
        if (cycle_tick) begin
          cyc_cnt <= (cyc_cnt == 3'(`SWR_CYCLES_PER_SAMPLE - 1)) ? 3'd0 : cyc_cnt + 3'd1;
        end
      end
    end
  end

  // Sample capture, waits for buffer room
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend      <= 1'b0;
      pend_cur  <= '0;
      pend_volt <= '0;
      pend_idx  <= '0;
      rec_index <= '0;
    end else begin
      if (start_detect) begin
        pend      <= 1'b0;
        rec_index <= '0;
      end else if (take) begin
        pend      <= 1'b1;
        pend_cur  <= max_cur;
        pend_volt <= rms_vac;
        pend_idx  <= rec_index;
        rec_index <= rec_index + 12'd1;
      end else if (pushed) begin
        pend <= 1'b0;
      end
    end
  end

  swr_buf2 #(.W(44)) u_buf (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (pend),
    .in_ready  (buf_ready),
    .in_data   ({pend_idx, pend_cur, pend_volt}),
    .out_valid (sample_valid),
    .out_ready (sample_ready),
    .out_data  ({sample_index, sample_current, sample_voltage})
  );

  // Remote orders and relay outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_cnt  <= 32'd0;
      hold_order <= 1'b0;
      relay_out  <= `SWR_RESET_RELAYS;
    end else begin
      if (remote_pulse_cmd) begin
        pulse_cnt <= PULSE_CYCLES;
      end else if (pulse_active) begin
        pulse_cnt <= pulse_cnt - 32'd1;
      end
      if (remote_hold_set) begin
        hold_order <= 1'b1;
      end else if (remote_hold_clear) begin
        hold_order <= 1'b0;
      end
      relay_out <= next_relay;
    end
  end

  // Pulse length counter for checks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_len <= 32'h0000_0000;
    end else if (remote_pulse_cmd) begin
      pulse_len <= 32'h0000_0000;
    end else if (pulse_active) begin
      pulse_len <= pulse_len + 32'h0000_0001;
    end
  end

  sequence cmd_pulse_s;
    remote_pulse_cmd;
  endsequence
  sequence pulse_on_s;
    pulse_active [*8];
  endsequence
  sequence pulse_fall_s;
    $fell(pulse_active);
  endsequence
  sequence rec_halt_s;
    recording && rec_cap && !start_detect;
  endsequence
  sequence start_tick_s;
    start_detect ##1 (cycle_tick && !start_detect);
  endsequence

  sample_take_a:   assert property (take |=> pend && pend_cur == $past(max_cur))
    else $error("sample not captured on fifth cycle");
  rms_volt_a:      assert property (take |=> pend_volt == $past(rms_vac))
    else $error("voltage sample wrong");
  new_start_a:     assert property (start_detect |=> record_start && rec_index == 0)
    else $error("new start did not reset recording");
  rec_begin_a:     assert property (start_detect |=> recording && rec_cnt == 0)
    else $error("recording did not begin");
  rec_end_a:       assert property (recording && start_time_delay && !start_detect |=> !recording)
    else $error("recording did not stop on delay");
  rec_cap_a:       assert property (rec_cnt < REC_MAX_CYCLES)
    else $error("recording exceeded length cap");
  pulse_map_a:     assert property (pulse_active && !hold_order |=>
                                    relay_out == $past(pulse_relay_assignment))
    else $error("pulse relay mapping wrong");
  pulse_hold_a:    assert property (cmd_pulse_s |=> pulse_on_s)
    else $error("pulse order dropped early");
  pulse_retrig_a:  assert property (remote_pulse_cmd |=> pulse_cnt == PULSE_CYCLES)
    else $error("pulse interval not restarted");
  hold_set_a:      assert property (remote_hold_set |=> hold_order ##1
                                    (relay_out & $past(hold_relay_assignment)) == $past(hold_relay_assignment))
    else $error("hold order not latched");
  hold_keep_a:     assert property (hold_order && !remote_hold_clear |=> hold_order)
    else $error("hold order dropped without command");
  hold_relay_a:    assert property (hold_order && !pulse_active |=>
                                    relay_out == $past(hold_relay_assignment))
    else $error("hold relays not following order");
  rec_limit_a:     assert property (rec_halt_s |=> !recording)
    else $error("recording not cut at length cap");
  rec_idle_a:      assert property (!recording && !start_detect |=> !recording)
    else $error("recording began without start");
  first_sample_a:  assert property (start_tick_s |=> pend && pend_idx == 12'h000)
    else $error("first sample not taken after start");
  index_step_a:    assert property (take |=> rec_index == $past(rec_index) + 12'h001)
    else $error("sample index did not advance");
  stale_drop_a:    assert property (start_detect |=> !pend)
    else $error("old sample kept after new start");
  sample_hold_a:   assert property (sample_valid && !sample_ready |=>
                                    sample_valid && $stable({sample_index, sample_current, sample_voltage}))
    else $error("sample word changed while stalled");
  pulse_length_a:  assert property (pulse_fall_s |-> pulse_len == PULSE_CYCLES)
    else $error("pulse order length wrong");
  relay_idle_a:    assert property (!pulse_active && !hold_order |=> relay_out == `SWR_RESET_RELAYS)
    else $error("relay driven without order");
  set_wins_a:      assert property (remote_hold_set && remote_hold_clear |=> hold_order)
    else $error("hold set lost to clear");
  hold_clear_a:    assert property (remote_hold_clear && !remote_hold_set |=> !hold_order)
    else $error("hold order not dropped");
endmodule : swr_recorder

// ===== testbench/start_waveform_recorder_test.sv
// Testbench for the start waveform recorder
`timescale 1ns/1ps
module start_waveform_recorder_test;
  import swr_pkg::*;
  logic       clk = 0, arst_n = 0, tick = 0, sd = 0, std = 0, pc = 0, hs = 0, hc = 0, stall = 1;
  logic       recording, record_start, sample_valid, sample_ready;
  swr_mag_t   ia = 16'h000A, ib = 16'h0030, ic = 16'h0020, vac = 16'h0155, cur, volt;
  swr_relay_t pm = 8'h05, hm = 8'h30, relay;
  swr_idx_t   idx;
  int         err_total = 0, compares = 0, cyc = 0;

  swr_recorder #(.PULSE_CYCLES(32'd20), .REC_MAX_CYCLES(32'd500)) dut (
    .clk(clk), .arst_n(arst_n), .cycle_tick(tick), .rms_current_a(ia), .rms_current_b(ib),
    .rms_current_c(ic), .rms_vac(vac), .start_detect(sd), .start_time_delay(std),
    .remote_pulse_cmd(pc), .remote_hold_set(hs), .remote_hold_clear(hc),
    .pulse_relay_assignment(pm), .hold_relay_assignment(hm), .relay_out(relay),
    .recording(recording), .record_start(record_start), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_current(cur), .sample_voltage(volt), .sample_index(idx));

  swr_sink sink (.clk(clk), .stall(stall), .valid(sample_valid), .ready(sample_ready),
    .word({idx, cur, volt}));

  always #25 clk = ~clk;

  task step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : step

  task chk(input logic [43:0] g, input logic [43:0] e);
    compares++;
    if (g !== e) begin
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
      err_total++;
    end
  endtask : chk

  task print_verdict;
    $display("err_total=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  task t_orders;
    pc = 1; step(1); pc = 0; step(1);
    chk(44'(relay), 44'(pm));
    step(9); pc = 1; step(1); pc = 0; step(17);
    chk(44'(relay), 44'(pm));
    step(20);
    chk(44'(relay), 44'h0);
    hs = 1; step(1); hs = 0; step(50);
    chk(44'(relay), 44'(hm));
    hc = 1; step(1); hc = 0; step(2);
    chk(44'(relay), 44'h0);
    hs = 1; hc = 1; pc = 1; step(1); hs = 0; hc = 0; pc = 0; step(2);
    chk(44'(relay), 44'(pm | hm));
    step(25);
    chk(44'(relay), 44'(hm));
    hc = 1; step(1); hc = 0; step(2);
    chk(44'(relay), 44'h0);
  endtask : t_orders

  task t_rec;
    sd = 1; step(1); sd = 0;
    chk(44'({recording, record_start}), 44'h3);
    for (int i = 0; i < 11; i++) begin
      tick = 1; step(1); tick = 0; step(3);
    end
    chk(44'(sample_valid), 44'h1);
    stall = 0; step(6);
    std = 1; step(1); std = 0; step(1);
    chk(44'(recording), 44'h0);
    tick = 1; step(1); tick = 0; step(4);
    chk(44'(sink.q.size()), 44'd3);
    for (int i = 0; i < 3; i++) begin
      chk(sink.q[i], {12'(i), ib, vac});
    end
    ic = 16'h0040; sd = 1; step(1); sd = 0;
    tick = 1; step(1); tick = 0; step(4);
    chk(sink.q[3], {12'h000, ic, vac});
    step(400);
    chk(44'(recording), 44'h1);
    step(120);
    chk(44'(recording), 44'h0);
  endtask : t_rec

  task t_reset;
    stall = 1; pc = 1; hs = 1; sd = 1; step(1); pc = 0; hs = 0; sd = 0;
    tick = 1; step(1); tick = 0; step(3);
    chk(44'({relay, recording, sample_valid}), 44'({pm | hm, 2'b11}));
    arst_n = 0; step(1);
    chk(44'({relay, recording, record_start, sample_valid}), 44'h0);
    arst_n = 1; step(2);
    chk(44'({relay, recording, sample_valid}), 44'h0);
    stall = 0;
  endtask : t_reset

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      print_verdict;
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    #5 arst_n = 1;
    step(1);
    t_orders;
    t_rec;
    t_reset;
    print_verdict;
  end
endmodule : start_waveform_recorder_test

// ===== testbench/swr_sink.sv
// Sample sink model of the supervisor side
`timescale 1ns/1ps
module swr_sink (
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic        valid,
  output logic             ready,
  input  wire logic [43:0] word
);
  logic [43:0] q[$];
  // Stalls only when the bench commands it
  assign ready = !stall;
  always @(posedge clk) begin
    if (valid && ready) q.push_back(word);
  end
endmodule : swr_sink
